/* File: core/bss_pkg.sv */
// Constants and types shared by the bypass switchover sequencer
// ****************************************************************
// Overview of operation
// [R1] Sequencing runs only when enable setting equals one
// [R2] Interlock wait between motor contactor changes
// [R3] Start wait after drive contactor closes
// [R4] Fault-bypass off: fault stops output, motor coasts
// [R5] Fault-bypass on: fault goes bypass, except thermal/processor
// [R6] Reaching switchover frequency moves drive to bypass
// [R7] Return band used only when switchover active
// [R8] Command below switchover minus band returns drive
// [R9] Run removal in auto bypass returns to drive
// [R10] Band 9999: run removal returns, decelerates to stop
// [R11] Supply contactor on; fault releases until reset - a drive fault taken to bypass recloses it once cleared, with no reset
// [R12] Bypass contactor only in bypass; thermal releases
// [R13] Drive contactor only in drive; fault releases
// [R14] Motor coasts before drive restarts from bypass
// [R15] Installer fits mechanical interlock between contactors
// [R16] Nothing runs without enable; select needs enable - enable input removal keeps a closed bypass contactor closed
// [R17] Run inputs honoured only with enable and select
// [R18] Bypass and drive contactors never on together
// [R19] Delays count from contactor output change edge
// ****************************************************************
package bss_pkg;
  // Register byte offsets
  localparam logic [7:0] BSS_OFS_CTRL = 8'h00;
  localparam logic [7:0] BSS_OFS_ILOCK = 8'h04;
  localparam logic [7:0] BSS_OFS_SWAIT = 8'h08;
  localparam logic [7:0] BSS_OFS_SWFREQ = 8'h0c;
  localparam logic [7:0] BSS_OFS_BAND = 8'h10;
  localparam logic [7:0] BSS_OFS_FOUT = 8'h14;
  localparam logic [7:0] BSS_OFS_FCMD = 8'h18;
  localparam logic [7:0] BSS_OFS_STATUS = 8'h1c;
  // Control field positions
  localparam int BSS_CTRL_SEQ_BIT = 0;
  localparam int BSS_CTRL_FBYP_BIT = 1;
  // Times in units of 0.1 s, frequencies in units of 0.01 Hz
  localparam logic [15:0] BSS_ILOCK_RST = 16'h000a;  // 1.0 s
  localparam logic [15:0] BSS_SWAIT_RST = 16'h0005;  // 0.5 s
  localparam logic [15:0] BSS_TIME_MAX = 16'h03e8;   // 100 s
  localparam logic [15:0] BSS_DISABLED = 16'h270f;   // 9999 means off
  localparam logic [15:0] BSS_SWFREQ_MAX = 16'h1770; // 60 Hz
  localparam logic [15:0] BSS_BAND_MAX = 16'h03e8;   // 10 Hz
  // Time base: 0.1 s tick at 50 MHz
  localparam int BSS_CLK_HZ = 50000000;
  localparam int BSS_TICK_MS = 100;
  localparam int BSS_TICK_CYC = BSS_CLK_HZ / 1000 * BSS_TICK_MS;
  // Sequencer states
  typedef enum logic [2:0] {
    BSS_IDLE, BSS_DRIVE_WAIT, BSS_DRIVE, BSS_TO_BYP, BSS_BYPASS, BSS_TO_DRV, BSS_FAULT
  } bss_state_e;
endpackage

/* File: core/bss_tick.sv */
// Prescaler producing the 0.1 s tick enable
`timescale 1ns/1ps
`default_nettype none
module bss_tick (
  input wire logic i_clk,
  input wire logic i_reset,
  output logic o_tick
);
  import bss_pkg::*;
  // ****************************************************************
  // Divider
  // ****************************************************************
  logic [22:0] cnt_r;  // Cycle counter within one tick
  // Free running, so a delay may lose up to one tick of its first period
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= 23'h0;
      o_tick <= 1'b0;
    end else if (cnt_r == 23'(BSS_TICK_CYC - 1)) begin
      cnt_r <= 23'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 23'h1;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: core/bss_top.sv */
// Bypass switchover sequencer with AXI4-Lite register access
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bss_top (
  input wire logic I_CLK,
  input wire logic I_RESET,
  // AXI4-Lite slave
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Operator and fault inputs
  input wire logic I_OPERATION_ENABLE_INPUT,
  input wire logic I_DRIVE_SELECT,
  input wire logic I_RUN_FORWARD,
  input wire logic I_RUN_REVERSE,
  input wire logic I_EXTERNAL_THERMAL_INPUT,  // High means motor overheated
  input wire logic I_DRIVE_FAULT,
  input wire logic I_THERMAL_TRIP_FAULT,
  input wire logic I_CPU_FAULT,
  input wire logic I_FAULT_RESET,
  // Contactor and drive outputs
  output logic O_SUPPLY_SIDE_CONTACTOR,
  output logic O_LINE_BYPASS_CONTACTOR,
  output logic O_DRIVE_OUTPUT_CONTACTOR,
  output logic O_DRIVE_RUN,
  output logic O_DECEL_STOP
);
  import bss_pkg::*;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic seq_en_r;           // Sequence enable setting
  logic fbyp_r;             // Bypass on fault setting
  logic [15:0] ilock_r;     // Interlock time, 0.1 s units
  logic [15:0] swait_r;     // Start wait, 0.1 s units
  logic [15:0] swfreq_r;    // Switchover frequency
  logic [15:0] band_r;      // Return band
  logic [15:0] fout_r;      // Output frequency fed by the drive core
  logic [15:0] fcmd_r;      // Frequency command
  bss_state_e state_r;      // Sequencer state
  logic [15:0] tmr_r;       // Delay counter in ticks
  logic auto_byp_r;         // Bypass reached by automatic switchover
  logic tick;               // 0.1 s enable

  // ****************************************************************
  // Time base
  // ****************************************************************
  bss_tick i_bss_tick (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .o_tick(tick)
  );

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  logic aw_have_r;          // Address latched
  logic w_have_r;           // Data latched
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [1:0] w_strb_r;     // Low strobes kept with the data, the bus may move on
  logic do_write;
  logic wr_ok;
  assign do_write = aw_have_r && w_have_r && !O_BVALID;
  assign wr_ok = (aw_addr_r <= BSS_OFS_FCMD) && (aw_addr_r[1:0] == 2'b00);

  // Address and data accepted independently, one write in flight
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 2'b00;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
    end else begin
      O_AWREADY <= !aw_have_r && !O_AWREADY && !O_BVALID;
      O_WREADY <= !w_have_r && !O_WREADY && !O_BVALID;
      if (I_AWVALID && O_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB[1:0];
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only address answers SLVERR
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_BVALID <= 1'b0;
      O_BRESP <= 2'b00;
    end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP <= wr_ok ? 2'b00 : 2'b10;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // Settings update; out of range values clamp to the top of range
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      seq_en_r <= 1'b0;
      fbyp_r <= 1'b0;
      ilock_r <= BSS_ILOCK_RST;
      swait_r <= BSS_SWAIT_RST;
      swfreq_r <= BSS_DISABLED;
      band_r <= BSS_DISABLED;
      fout_r <= 16'h0;
      fcmd_r <= 16'h0;
    end else if (do_write && wr_ok && (&w_strb_r)) begin
      unique case (aw_addr_r)
        BSS_OFS_CTRL: begin
          seq_en_r <= w_data_r[BSS_CTRL_SEQ_BIT];
          fbyp_r <= w_data_r[BSS_CTRL_FBYP_BIT];
        end
        BSS_OFS_ILOCK: ilock_r <= (w_data_r[15:0] > BSS_TIME_MAX) ? BSS_TIME_MAX : w_data_r[15:0];
        BSS_OFS_SWAIT: swait_r <= (w_data_r[15:0] > BSS_TIME_MAX) ? BSS_TIME_MAX : w_data_r[15:0];
        BSS_OFS_SWFREQ: swfreq_r <= (w_data_r[15:0] == BSS_DISABLED || w_data_r[15:0] <= BSS_SWFREQ_MAX) ?
                                    w_data_r[15:0] : BSS_SWFREQ_MAX;
        BSS_OFS_BAND: band_r <= (w_data_r[15:0] == BSS_DISABLED || w_data_r[15:0] <= BSS_BAND_MAX) ?
                                w_data_r[15:0] : BSS_BAND_MAX;
        BSS_OFS_FOUT: fout_r <= w_data_r[15:0];
        BSS_OFS_FCMD: fcmd_r <= w_data_r[15:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (I_ARADDR)
      BSS_OFS_CTRL: rd_mux = {30'h0, fbyp_r, seq_en_r};
      BSS_OFS_ILOCK: rd_mux = {16'h0, ilock_r};
      BSS_OFS_SWAIT: rd_mux = {16'h0, swait_r};
      BSS_OFS_SWFREQ: rd_mux = {16'h0, swfreq_r};
      BSS_OFS_BAND: rd_mux = {16'h0, band_r};
      BSS_OFS_FOUT: rd_mux = {16'h0, fout_r};
      BSS_OFS_FCMD: rd_mux = {16'h0, fcmd_r};
      BSS_OFS_STATUS: rd_mux = {25'h0, auto_byp_r, 2'b00, state_r, 1'b0};
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read answered one cycle after the address is taken
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= 2'b00;
    end else begin
      O_ARREADY <= !O_ARREADY && !O_RVALID && I_ARVALID;
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RDATA <= rd_mux;
        O_RRESP <= rd_ok ? 2'b00 : 2'b10;
      end else if (I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequencer decisions
  // ****************************************************************
  logic auto_on;            // Automatic switchover active
  logic run_cmd;            // Honoured run command
  logic want_drive;         // Operator selects drive
  logic fault_any;          // Any drive fault
  logic fault_to_byp;       // Fault that may go to bypass
  logic back_by_freq;       // Command fell under the return point
  logic tmr_done;
  logic seq_ready;          // Sequencing allowed at all
  logic auto_go;            // Output frequency reached switchover point
  logic back_go;            // Leave bypass for drive
  assign auto_on = (swfreq_r != BSS_DISABLED);
  assign run_cmd = I_OPERATION_ENABLE_INPUT && I_DRIVE_SELECT && (I_RUN_FORWARD || I_RUN_REVERSE); // [R17]
  assign want_drive = I_DRIVE_SELECT;
  // Hot motor trips like a fault, so every contactor opens until reset
  assign fault_any = I_DRIVE_FAULT || I_THERMAL_TRIP_FAULT || I_CPU_FAULT || I_EXTERNAL_THERMAL_INPUT; // [R12]
  assign fault_to_byp = fbyp_r && I_DRIVE_FAULT && !I_THERMAL_TRIP_FAULT && !I_CPU_FAULT // [R5]
                        && !I_EXTERNAL_THERMAL_INPUT;
  assign back_by_freq = auto_on && (band_r != BSS_DISABLED) && // [R7]
                        ({1'b0, fcmd_r} + {1'b0, band_r} < {1'b0, swfreq_r}); // [R8]
  assign tmr_done = (tmr_r == 16'h0);

  // Interlock and start wait timer, loaded as a contactor output changes
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      tmr_r <= 16'h0;
    end else if ((state_r == BSS_DRIVE && (!want_drive || (auto_on && auto_go))) ||
                 (state_r == BSS_BYPASS && back_go) ||
                 (fault_to_byp && state_r != BSS_TO_BYP && state_r != BSS_BYPASS && state_r != BSS_FAULT) ||
                 (state_r == BSS_IDLE && seq_ready && want_drive)) begin
      // Manual and fault switchovers to bypass keep the same interlock gap
      tmr_r <= (state_r == BSS_IDLE && !fault_to_byp) ? swait_r : ilock_r; // [R19] [R2] [R3]
    end else if (state_r == BSS_TO_DRV && tmr_done) begin
      tmr_r <= swait_r; // [R3] [R19]
    end else if (tick && !tmr_done) begin
      tmr_r <= tmr_r - 16'h1;
    end
  end

  assign seq_ready = seq_en_r && I_OPERATION_ENABLE_INPUT; // [R1] [R16]
  assign auto_go = run_cmd && (fout_r >= swfreq_r); // [R6]
  assign back_go = !want_drive ? 1'b0 :
                   auto_byp_r ? (back_by_freq || !(I_RUN_FORWARD || I_RUN_REVERSE)) : 1'b1; // [R9] [R10]

  // Main state machine; faults and disable take precedence
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_r <= BSS_IDLE;
      auto_byp_r <= 1'b0;
    end else if (state_r == BSS_FAULT) begin
      if (I_FAULT_RESET && !fault_any) begin
        state_r <= BSS_IDLE; // [R11]
      end
    end else if (fault_any && !((state_r == BSS_TO_BYP || state_r == BSS_BYPASS) && fault_to_byp)) begin
      state_r <= fault_to_byp ? BSS_TO_BYP : BSS_FAULT; // [R4] [R5]
      auto_byp_r <= 1'b0;
    end else if (!seq_ready) begin
      // Enable input removal holds contactors in place so the motor is not dropped; clearing the enable setting returns to idle
      if (!seq_en_r) begin
        state_r <= BSS_IDLE;
      end
    end else begin
      unique case (state_r)
        BSS_IDLE: state_r <= want_drive ? BSS_DRIVE_WAIT : BSS_TO_BYP;
        BSS_DRIVE_WAIT: if (tmr_done) state_r <= BSS_DRIVE;
        BSS_DRIVE: begin
          if (!want_drive || (auto_on && auto_go)) begin
            state_r <= BSS_TO_BYP;
            auto_byp_r <= want_drive;
          end
        end
        BSS_TO_BYP: if (tmr_done) state_r <= BSS_BYPASS; // [R2]
        BSS_BYPASS: begin
          if (back_go) begin
            state_r <= BSS_TO_DRV; // [R14]
          end
        end
        BSS_TO_DRV: begin
          if (tmr_done) begin
            state_r <= BSS_DRIVE_WAIT;
            auto_byp_r <= 1'b0;
          end
        end
        BSS_FAULT: state_r <= BSS_FAULT;
      endcase
    end
  end

  // ****************************************************************
  // Contactor and drive outputs, all registered
  // ****************************************************************
  logic byp_nxt;
  logic drv_nxt;
  // Only a fault that may go to bypass keeps the line contactor closed
  assign byp_nxt = (state_r == BSS_BYPASS) && !I_EXTERNAL_THERMAL_INPUT && (!fault_any || fault_to_byp); // [R12]
  assign drv_nxt = (state_r == BSS_DRIVE_WAIT || state_r == BSS_DRIVE) && !fault_any; // [R13]

  // Bypass and drive contactors derived from exclusive states
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SUPPLY_SIDE_CONTACTOR <= 1'b0;
      O_LINE_BYPASS_CONTACTOR <= 1'b0;
      O_DRIVE_OUTPUT_CONTACTOR <= 1'b0;
      O_DRIVE_RUN <= 1'b0;
      O_DECEL_STOP <= 1'b0;
    end else begin
      O_SUPPLY_SIDE_CONTACTOR <= seq_en_r && state_r != BSS_FAULT && !fault_any; // [R11]
      O_LINE_BYPASS_CONTACTOR <= byp_nxt && !drv_nxt; // [R18]
      O_DRIVE_OUTPUT_CONTACTOR <= drv_nxt && !byp_nxt; // [R18]
      O_DRIVE_RUN <= (state_r == BSS_DRIVE) && run_cmd && !fault_any;
      // Drive ramps down after returning with the run removed
      O_DECEL_STOP <= (state_r == BSS_DRIVE) && !run_cmd && auto_on && (band_r == BSS_DISABLED); // [R10]
    end
  end
endmodule
`default_nettype wire

/* File: tb/bss_plant.sv */
// Contactor coils and thermal relay on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module bss_plant (
  input wire logic i_clk,
  input wire logic i_bypass_coil,
  input wire logic i_drive_coil,
  input wire logic i_overheat,
  output logic o_thermal,
  output logic [7:0] o_clashes
);
  // Relay contact simply follows motor temperature
  assign o_thermal = i_overheat;
  // Interlock bar would jam here; count every clash so the bench sees it
  initial o_clashes = 8'h00;
  always @(posedge i_clk) begin
    if (i_bypass_coil && i_drive_coil) begin
      o_clashes <= o_clashes + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: tb/bss_top_asserts.sv */
// Concurrent checks on the sequencer contactor and run outputs
`timescale 1ns/1ps
`default_nettype none
module bss_top_asserts (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_OPERATION_ENABLE_INPUT,
  input wire logic I_DRIVE_FAULT,
  input wire logic I_THERMAL_TRIP_FAULT,
  input wire logic I_CPU_FAULT,
  input wire logic I_EXTERNAL_THERMAL_INPUT,
  input wire logic O_SUPPLY_SIDE_CONTACTOR,
  input wire logic O_LINE_BYPASS_CONTACTOR,
  input wire logic O_DRIVE_OUTPUT_CONTACTOR,
  input wire logic O_DRIVE_RUN
);
  // ****************************************
  // Clocking and named steps
  // ****************************************
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // Both motor contactors open
  sequence s_motor_free; !O_LINE_BYPASS_CONTACTOR && !O_DRIVE_OUTPUT_CONTACTOR; endsequence
  // Drive side fully cut off
  sequence s_cut; !O_SUPPLY_SIDE_CONTACTOR && !O_DRIVE_OUTPUT_CONTACTOR && !O_DRIVE_RUN; endsequence
  // No enable and no fault for two samples
  sequence s_quiet;
    (!I_OPERATION_ENABLE_INPUT && !I_DRIVE_FAULT && !I_CPU_FAULT && !I_THERMAL_TRIP_FAULT &&
     !I_EXTERNAL_THERMAL_INPUT) [*2];
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  property p_exclusive; !(O_LINE_BYPASS_CONTACTOR && O_DRIVE_OUTPUT_CONTACTOR); endproperty
  a_exclusive: assert property (p_exclusive) else $error("motor contactors closed together");
  property p_fault_cut; I_DRIVE_FAULT |=> s_cut; endproperty
  a_fault_cut: assert property (p_fault_cut) else $error("drive fault left drive side on");
  property p_cpu_cut; I_CPU_FAULT |=> s_cut ##0 s_motor_free; endproperty
  a_cpu_cut: assert property (p_cpu_cut) else $error("processor fault not fully released");
  property p_hot; I_EXTERNAL_THERMAL_INPUT |=> s_motor_free; endproperty
  a_hot: assert property (p_hot) else $error("motor contactor on with hot motor");
  property p_gap; $rose(O_LINE_BYPASS_CONTACTOR) |-> !$past(O_DRIVE_OUTPUT_CONTACTOR); endproperty
  a_gap: assert property (p_gap) else $error("bypass closed right after drive opened");
  property p_coast; $rose(O_DRIVE_OUTPUT_CONTACTOR) |-> !$past(O_LINE_BYPASS_CONTACTOR); endproperty
  a_coast: assert property (p_coast) else $error("drive closed with no coast gap");
  property p_start; $rose(O_DRIVE_RUN) |-> $past(O_DRIVE_OUTPUT_CONTACTOR); endproperty
  a_start: assert property (p_start) else $error("drive output before contactor");
  property p_run_path; O_DRIVE_RUN |-> O_DRIVE_OUTPUT_CONTACTOR; endproperty
  a_run_path: assert property (p_run_path) else $error("drive runs with contactor open");
  property p_resupply; $rose(O_SUPPLY_SIDE_CONTACTOR) |-> !$past(I_DRIVE_FAULT); endproperty
  a_resupply: assert property (p_resupply) else $error("supply closed during fault");
  property p_hold; s_quiet |-> $stable(O_LINE_BYPASS_CONTACTOR) && $stable(O_DRIVE_OUTPUT_CONTACTOR); endproperty
  a_hold: assert property (p_hold) else $error("motor contactor moved without enable");
endmodule
`default_nettype wire

/* File: tb/bss_top_test.sv */
// Self-checking bench for the bypass switchover sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module bss_top_test;
  import bss_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk = '0, rst = '1, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [7:0] awaddr = '0, araddr = '0, clashes;
  logic [31:0] wdata = '0, rdata, last_rd;
  logic en = '0, sel = '0, fwd = '0, rev = '0, dflt = '0, tflt = '0, cflt = '0, frst = '0, hot = '0;
  logic ext_hot, awready, wready, bvalid, arready, rvalid, sup, byp, drv, run, decel;
  logic [1:0] bresp, rresp;
  int failures = 0, checks_done = 0;
  bss_top i_bss_top (.I_CLK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_OPERATION_ENABLE_INPUT(en), .I_DRIVE_SELECT(sel),
    .I_RUN_FORWARD(fwd), .I_RUN_REVERSE(rev), .I_EXTERNAL_THERMAL_INPUT(ext_hot), .I_DRIVE_FAULT(dflt),
    .I_THERMAL_TRIP_FAULT(tflt), .I_CPU_FAULT(cflt), .I_FAULT_RESET(frst), .O_SUPPLY_SIDE_CONTACTOR(sup),
    .O_LINE_BYPASS_CONTACTOR(byp), .O_DRIVE_OUTPUT_CONTACTOR(drv), .O_DRIVE_RUN(run), .O_DECEL_STOP(decel));
  bss_plant i_bss_plant (.i_clk(clk), .i_bypass_coil(byp), .i_drive_coil(drv), .i_overheat(hot),
    .o_thermal(ext_hot), .o_clashes(clashes));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Verdict and bus tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Write: offer address and data together, drop each once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ah, wh;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        break;
      end
    end
    if (n == 64) begin
      failures++;
      report_and_stop();
    end
    `CHK(r, er)
  endtask
  // Read: hold address until taken, keep last data for callers
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ah;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      ah = arvalid && arready;
      r = rresp;
      last_rd = rdata;
      @(posedge clk);
      if (ah) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        break;
      end
    end
    if (n == 64) begin
      failures++;
      report_and_stop();
    end
    `CHK(r, er)
    `CHK(last_rd, ed)
  endtask
  // Hang guard well under the cycle budget
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    `CHK({sup, byp, drv, run, decel}, 5'h00)
    rd(BSS_OFS_CTRL, 32'h0, 2'h0);
    rd(BSS_OFS_ILOCK, {16'h0, BSS_ILOCK_RST}, 2'h0);
    rd(BSS_OFS_SWAIT, {16'h0, BSS_SWAIT_RST}, 2'h0);
    rd(BSS_OFS_SWFREQ, {16'h0, BSS_DISABLED}, 2'h0);
    rd(BSS_OFS_BAND, {16'h0, BSS_DISABLED}, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(BSS_OFS_STATUS, 32'h0, 2'h2);
    wr(BSS_OFS_ILOCK, 32'h7d0, 2'h0);
    rd(BSS_OFS_ILOCK, {16'h0, BSS_TIME_MAX}, 2'h0);
    wr(BSS_OFS_SWFREQ, {16'h0, BSS_SWFREQ_MAX}, 2'h0);
    rd(BSS_OFS_SWFREQ, {16'h0, BSS_SWFREQ_MAX}, 2'h0);
    wr(BSS_OFS_BAND, {16'h0, BSS_BAND_MAX}, 2'h0);
    rd(BSS_OFS_BAND, {16'h0, BSS_BAND_MAX}, 2'h0);
    // Zero delays: a real tick lies far beyond the run length
    wr(BSS_OFS_ILOCK, 32'h0, 2'h0);
    wr(BSS_OFS_SWAIT, 32'h0, 2'h0);
    // Operator asks to run while sequencing is off: nothing may close
    en <= 1'h1;
    sel <= 1'h1;
    fwd <= 1'h1;
    rev <= 1'h1;
    repeat (20) @(posedge clk);
    `CHK({byp, drv, run}, 3'h0)
    rd(BSS_OFS_STATUS, 32'h0, 2'h0);
    // Fault-bypass off: fault cuts drive side and parks in fault state
    wr(BSS_OFS_CTRL, 32'h1, 2'h0);
    dflt <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    `CHK({sup, drv, run}, 3'h0)
    rd(BSS_OFS_STATUS, 32'hc, 2'h0);
    dflt <= 1'h0;
    frst <= 1'h1;
    repeat (3) @(posedge clk);
    frst <= 1'h0;
    rd(BSS_OFS_STATUS, 32'h4, 2'h0);
    @(negedge clk);
    `CHK({sup, drv, run}, 3'h7)
    `CHK(last_rd[3:1] != 3'h6, 1'h1)
    // Fault-bypass on: processor and thermal trip faults must still go to the fault state, not bypass
    wr(BSS_OFS_CTRL, 32'h3, 2'h0);
    for (int k = 0; k < 2; k++) begin
      cflt <= (k == 0);
      tflt <= (k == 1);
      @(posedge clk);
      @(negedge clk);
      `CHK({byp, drv, run}, 3'h0)
      rd(BSS_OFS_STATUS, 32'hc, 2'h0);
      cflt <= 1'h0;
      tflt <= 1'h0;
      frst <= 1'h1;
      repeat (3) @(posedge clk);
      frst <= 1'h0;
    end
    // Automatic switchover up at the set frequency, back below the band
    wr(BSS_OFS_FCMD, 32'h1388, 2'h0);
    wr(BSS_OFS_FOUT, 32'h1770, 2'h0);
    rd(BSS_OFS_STATUS, 32'h48, 2'h0);
    @(negedge clk);
    `CHK({sup, byp, drv, run}, 4'hc)
    wr(BSS_OFS_FOUT, 32'h0, 2'h0);
    rd(BSS_OFS_STATUS, 32'h48, 2'h0);
    wr(BSS_OFS_FCMD, 32'h1387, 2'h0);
    rd(BSS_OFS_STATUS, 32'h4, 2'h0);
    @(negedge clk);
    `CHK({byp, drv, run, decel}, 4'h6)
    // Band off: only removing the run brings the drive back, ramping down
    wr(BSS_OFS_BAND, {16'h0, BSS_DISABLED}, 2'h0);
    wr(BSS_OFS_FOUT, 32'h1770, 2'h0);
    rd(BSS_OFS_STATUS, 32'h48, 2'h0);
    fwd <= 1'h0;
    rev <= 1'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK({byp, drv, run, decel}, 4'h5)
    // Overheated motor opens both motor contactors
    hot <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK({byp, drv}, 2'h0)
    `CHK(clashes, 8'h00)
    report_and_stop();
  end
endmodule
bind bss_top bss_top_asserts i_bss_top_asserts (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_OPERATION_ENABLE_INPUT(I_OPERATION_ENABLE_INPUT), .I_DRIVE_FAULT(I_DRIVE_FAULT),
  .I_THERMAL_TRIP_FAULT(I_THERMAL_TRIP_FAULT), .I_CPU_FAULT(I_CPU_FAULT),
  .I_EXTERNAL_THERMAL_INPUT(I_EXTERNAL_THERMAL_INPUT), .O_SUPPLY_SIDE_CONTACTOR(O_SUPPLY_SIDE_CONTACTOR),
  .O_LINE_BYPASS_CONTACTOR(O_LINE_BYPASS_CONTACTOR), .O_DRIVE_OUTPUT_CONTACTOR(O_DRIVE_OUTPUT_CONTACTOR),
  .O_DRIVE_RUN(O_DRIVE_RUN));
`default_nettype wire
